// ### hdl/rat_core.sv
// ringer qualifier, two-tone alerter and dial tone-code control
// assumes pins arrive asynchronous; analog comparator gives ring level
//
// Contract
// R1 - up/down counter qualifies ringing, rejects noise
// R2 - alerter drives only after positive ring decision
// R3 - alert toggles pair at 20 Hz; low 1200/1500
// R4 - select high gives 1800/2250; open means low
// R5 - outputs support differential or single-ended drive
// R6 - ignore tone code on-hook or speech-only
// R7 - code presented first, latched on strobe rise
// R8 - controller strobes again after changing code
// R9 - feature flag pulled low off-hook, open speech-only
// R10 - logic timing divided from 480 kHz rate
// R11 - row and column tone frequencies per table
// R12 - two rows/columns single tone; diagonal none
// R13 - dialing switches tones in, attenuates receive
// R14 - latched code holds until next strobe/disable
`timescale 1ns/1ps
`default_nettype none
module rat_core #(
    parameter int RING_MAX  = rat_pkg::RING_MAX,  // ring qualifier top count
    parameter int ALT_TICKS = rat_pkg::ALT_TICKS  // ticks per alert tone
) (
    input  wire logic       i_clk,                  // 20 MHz clock
    input  wire logic       i_reset_n,              // async reset, low
    input  wire logic       i_ring_level,           // line magnitude over limit
    input  wire logic       i_hook_switch_sense,    // high when off-hook
    input  wire logic       i_long_loop,            // speech-only low power
    input  wire logic       i_alert_freq_select,    // pair select, open = low
    input  wire logic [4:0] i_tone_code,            // tone code bits 4..0
    input  wire logic       i_tone_code_strobe,     // latch strobe
    output logic            o_alert_out_a,          // alerter drive a
    output logic            o_alert_out_b,          // alerter drive b
    output logic            o_ring_detected,        // ring qualified
    output logic            o_feature_mode_flag_out,// open-drain level, always 0
    output logic            o_feature_mode_flag_oe, // high pulls flag low
    output logic            o_row_tone,             // low-group square wave
    output logic            o_col_tone,             // high-group square wave
    output logic            o_dial_active,          // converter into transmit
    output logic            o_rx_attenuate          // receive path cut
);
    // ==========================================================
    // input synchronisers
    localparam int SYNC_W = 10; // synchronised bit count
    logic [SYNC_W-1:0] sync1_r; // first stage, read only by second
    logic [SYNC_W-1:0] sync2_r; // safe copies
    logic          strb_d_r; // strobe delayed for edge detect

    // two flops per pin; nothing else reads the first stage
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            sync1_r  <= '0;
            sync2_r  <= '0;
            strb_d_r <= 1'b0;
        end else begin
            sync1_r  <= {i_ring_level, i_hook_switch_sense, i_long_loop,
                         i_alert_freq_select, i_tone_code_strobe, i_tone_code};
            sync2_r  <= sync1_r;
            strb_d_r <= sync2_r[5];
        end
    end

    wire       ring_s   = sync2_r[9];     // ring comparator
    wire       hook_s   = sync2_r[8];     // off-hook
    wire       loop_s   = sync2_r[7];     // speech-only request
    wire       sel_s    = sync2_r[6];     // alert pair select
    wire       strb_s   = sync2_r[5];     // strobe
    wire [4:0] code_s   = sync2_r[4:0];   // tone code
    wire       strb_rise = strb_s & ~strb_d_r;
    // code inputs live only off-hook in full feature mode
    wire       inputs_en = hook_s & ~loop_s; // [R6]

    // ==========================================================
    // resonator-rate tick
    logic [5:0] res_cnt_r; // clock divider
    wire        res_tick = (res_cnt_r == rat_pkg::RES_LAST);

    // every logic timing step comes from this divided rate
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            res_cnt_r <= 6'h00;
        end else if (res_tick) begin
            res_cnt_r <= 6'h00; // [R10]
        end else begin
            res_cnt_r <= res_cnt_r + 6'h01;
        end
    end

    // ==========================================================
    // ring qualifier
    localparam logic [11:0] RMAX = 12'(RING_MAX); // saturation value
    rat_pkg::rat_ring_e qual_state_r;   // qualifier state
    rat_pkg::rat_ring_e qual_state_nxt; // next state
    logic [11:0]        ring_cnt_r; // evidence count
    logic [11:0]        ring_cnt_nxt;

    // up on a high sample, down on a low one; noise bursts
    // drain back to zero before reaching the top
    always_comb begin
        ring_cnt_nxt = ring_cnt_r;
        if (hook_s) begin
            ring_cnt_nxt = 12'h000; // off-hook: no ringing
        end else if (res_tick) begin
            if (ring_s && ring_cnt_r != RMAX) begin
                ring_cnt_nxt = ring_cnt_r + 12'h001; // [R1]
            end else if (!ring_s && ring_cnt_r != 12'h000) begin
                ring_cnt_nxt = ring_cnt_r - 12'h001; // [R1]
            end
        end
    end

    // decision with hysteresis: set at top, clear at zero
    always_comb begin
        qual_state_nxt = qual_state_r;
        case (qual_state_r)
            rat_pkg::RAT_IDLE: begin
                if (ring_cnt_nxt != 12'h000) qual_state_nxt = rat_pkg::RAT_QUAL;
            end
            rat_pkg::RAT_QUAL: begin
                if (ring_cnt_nxt == RMAX) qual_state_nxt = rat_pkg::RAT_ALERT;  // [R1]
                else if (ring_cnt_nxt == 12'h000) qual_state_nxt = rat_pkg::RAT_IDLE;
            end
            rat_pkg::RAT_ALERT: begin
                if (ring_cnt_nxt == 12'h000) qual_state_nxt = rat_pkg::RAT_IDLE;
            end
            default: qual_state_nxt = rat_pkg::RAT_IDLE;
        endcase
    end

    // qualifier registers
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            qual_state_r <= rat_pkg::RAT_IDLE;
            ring_cnt_r   <= 12'h000;
        end else begin
            qual_state_r <= qual_state_nxt;
            ring_cnt_r   <= ring_cnt_nxt;
        end
    end

    wire alerting = (qual_state_r == rat_pkg::RAT_ALERT);

    // ==========================================================
    // alert pair alternation
    localparam logic [13:0] ALT_LAST = 14'(ALT_TICKS - 1); // last count of each tone
    logic [13:0] alt_cnt_r; // time in current tone
    logic        alt_r;     // 0 first tone, 1 second tone

    // swap tones twice per 20 Hz cycle while alerting
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            alt_cnt_r <= 14'h0000;
            alt_r     <= 1'b0;
        end else if (!alerting) begin
            alt_cnt_r <= 14'h0000;
            alt_r     <= 1'b0;
        end else if (res_tick) begin
            if (alt_cnt_r == ALT_LAST) begin
                alt_cnt_r <= 14'h0000;
                alt_r     <= ~alt_r; // [R3]
            end else begin
                alt_cnt_r <= alt_cnt_r + 14'h0001;
            end
        end
    end

    // pair choice; a floating select is pulled low outside
    wire [8:0] al_half = sel_s ? (alt_r ? rat_pkg::HP_AL_HI1 : rat_pkg::HP_AL_HI0)  // [R4]
                               : (alt_r ? rat_pkg::HP_AL_LO1 : rat_pkg::HP_AL_LO0); // [R3]

    // ==========================================================
    // tone code latch and decode
    logic [4:0] code_r; // latched code

    // capture on the strobe rise only while enabled; an
    // unchanged code with no new strobe simply stays put
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            code_r <= rat_pkg::CODE_IDLE;
        end else if (!inputs_en) begin
            code_r <= rat_pkg::CODE_IDLE; // [R6] [R14]
        end else if (strb_rise) begin
            code_r <= code_s;             // [R7] [R8]
        end
    end

    wire [6:0] pat  = rat_pkg::rat_key_map(code_r);
    wire [3:0] rows = pat[6:3]; // active rows
    wire [2:0] cols = pat[2:0]; // active columns
    // a group sounds only with a single line of its own and
    // a partner line crossed; a diagonal kills both
    wire row_on = $onehot(rows) && (cols != 3'h0); // [R12]
    wire col_on = $onehot(cols) && (rows != 4'h0); // [R12]

    // row and column half periods
    wire [8:0] row_half = rows[0] ? rat_pkg::HP_ROW1 :
                          rows[1] ? rat_pkg::HP_ROW2 :
                          rows[2] ? rat_pkg::HP_ROW3 : rat_pkg::HP_ROW4; // [R11]
    wire [8:0] col_half = cols[0] ? rat_pkg::HP_COL1 :
                          cols[1] ? rat_pkg::HP_COL2 : rat_pkg::HP_COL3; // [R11]

    // ==========================================================
    // three square-wave generators: row, column, alert
    wire [8:0] half [3];   // half period per channel
    wire [2:0] run;        // channel running
    logic [8:0] tcnt_r [3]; // channel counters
    logic [2:0] tone_r;     // channel levels
    assign half[0] = row_half;
    assign half[1] = col_half;
    assign half[2] = al_half;
    assign run     = {alerting, col_on, row_on};

    genvar g;
    generate
        for (g = 0; g < 3; g++) begin : g_tone
            // idle channels park low so a restart is glitch free
            always_ff @(posedge i_clk or negedge i_reset_n) begin
                if (!i_reset_n) begin
                    tcnt_r[g] <= 9'h000;
                    tone_r[g] <= 1'b0;
                end else if (!run[g]) begin
                    tcnt_r[g] <= 9'h000;
                    tone_r[g] <= 1'b0;
                end else if (res_tick) begin
                    if (tcnt_r[g] >= half[g] - 9'h001) begin
                        tcnt_r[g] <= 9'h000;
                        tone_r[g] <= ~tone_r[g];
                    end else begin
                        tcnt_r[g] <= tcnt_r[g] + 9'h001;
                    end
                end
            end
        end
    endgenerate

    // ==========================================================
    // output registers
    logic al_a_r, al_b_r, det_r, oe_r, row_r, col_r, dial_r, rxa_r;

    // complementary alert legs give double swing across a
    // transducer; leg a alone serves single-ended use
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            al_a_r  <= 1'b0;
            al_b_r  <= 1'b0;
            det_r   <= 1'b0;
            oe_r    <= 1'b0;
            row_r   <= 1'b0;
            col_r   <= 1'b0;
            dial_r  <= 1'b0;
            rxa_r   <= 1'b0;
        end else begin
            al_a_r  <= alerting & tone_r[2];      // [R2] [R5]
            al_b_r  <= alerting & ~tone_r[2];     // [R2] [R5]
            det_r   <= alerting;
            oe_r    <= inputs_en;                 // [R9]
            row_r   <= row_on & tone_r[0];
            col_r   <= col_on & tone_r[1];
            dial_r  <= row_on | col_on;           // [R13]
            rxa_r   <= row_on | col_on;           // [R13]
        end
    end

    assign o_alert_out_a           = al_a_r;
    assign o_alert_out_b           = al_b_r;
    assign o_ring_detected         = det_r;
    assign o_feature_mode_flag_out = 1'b0;
    assign o_feature_mode_flag_oe  = oe_r;
    assign o_row_tone              = row_r;
    assign o_col_tone              = col_r;
    assign o_dial_active           = dial_r;
    assign o_rx_attenuate          = rxa_r;

    // ==========================================================
    // checks
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_reset_n);

    chk_ring_count_up: assert property ( // [R1]
        (res_tick && !hook_s && ring_s && ring_cnt_r != RMAX)
            |=> ring_cnt_r == $past(ring_cnt_r) + 12'h001)
        else $error("ring count did not step up");
    chk_alert_gated: assert property ( // [R2]
        !alerting |=> !o_alert_out_a && !o_alert_out_b)
        else $error("alerter driven without decision");
    chk_pair_low: assert property ( // [R3]
        (!sel_s && !alt_r) |-> al_half == rat_pkg::HP_AL_LO0)
        else $error("wrong low pair first tone");
    chk_pair_high: assert property ( // [R4]
        (sel_s && alt_r) |-> al_half == rat_pkg::HP_AL_HI1)
        else $error("wrong high pair second tone");
    chk_alert_diff: assert property ( // [R5]
        alerting |=> o_alert_out_a != o_alert_out_b)
        else $error("alert legs not complementary");
    chk_code_ignored: assert property ( // [R6]
        (!inputs_en ##1 !inputs_en) |=> !o_dial_active)
        else $error("tone active while inputs disabled");
    chk_latch_strobe: assert property ( // [R7]
        (inputs_en && strb_rise) |=> code_r == $past(code_s))
        else $error("code not latched on strobe");
    chk_fm_follow: assert property ( // [R9]
        inputs_en |=> o_feature_mode_flag_oe)
        else $error("feature flag not pulled low");
    chk_fm_release: assert property ( // [R9]
        !inputs_en |=> !o_feature_mode_flag_oe)
        else $error("feature flag not released");
    chk_tick_space: assert property ( // [R10]
        res_tick |=> !res_tick)
        else $error("resonator ticks back to back");
    chk_row_freq: assert property ( // [R11]
        rows == 4'h1 |-> row_half == rat_pkg::HP_ROW1)
        else $error("row one frequency wrong");
    chk_diag_silent: assert property ( // [R12]
        code_r == rat_pkg::CODE_DIAG |=> !o_dial_active && !o_row_tone && !o_col_tone)
        else $error("diagonal produced a tone");
    chk_rx_atten: assert property ( // [R13]
        o_rx_attenuate == o_dial_active)
        else $error("receive cut not tied to dialing");
    chk_code_hold: assert property ( // [R14]
        (inputs_en && !strb_rise) |=> $stable(code_r))
        else $error("latched code changed without strobe");
endmodule
`default_nettype wire

// ### hdl/rat_pkg.sv
// constants for the ringer, alerter and tone-code control block
// assumes one 20 MHz system clock standing in for the resonator
`default_nettype none
package rat_pkg;
    // ==========================================================
    // clocking
    localparam int CLK_HZ  = 20000000;           // system clock rate
    localparam int RES_HZ  = 480000;             // resonator rate
    localparam int RES_DIV = CLK_HZ / RES_HZ;    // clocks per resonator tick (rounded down)
    localparam logic [5:0] RES_LAST = 6'(RES_DIV - 1); // divider wrap value

    // ==========================================================
    // tone frequencies in hertz
    localparam int F_AL_LO0 = 1200;  // alert pair, select low
    localparam int F_AL_LO1 = 1500;
    localparam int F_AL_HI0 = 1800;  // alert pair, select high
    localparam int F_AL_HI1 = 2250;
    localparam int F_ALT    = 20;    // alert pair repetition rate
    localparam int F_ROW1 = 697;
    localparam int F_ROW2 = 770;
    localparam int F_ROW3 = 852;
    localparam int F_ROW4 = 941;
    localparam int F_COL1 = 1209;
    localparam int F_COL2 = 1336;
    localparam int F_COL3 = 1477;

    // ==========================================================
    // half periods in resonator ticks
    localparam logic [8:0] HP_AL_LO0 = 9'(RES_HZ / (2 * F_AL_LO0));
    localparam logic [8:0] HP_AL_LO1 = 9'(RES_HZ / (2 * F_AL_LO1));
    localparam logic [8:0] HP_AL_HI0 = 9'(RES_HZ / (2 * F_AL_HI0));
    localparam logic [8:0] HP_AL_HI1 = 9'(RES_HZ / (2 * F_AL_HI1));
    localparam logic [8:0] HP_ROW1 = 9'(RES_HZ / (2 * F_ROW1));
    localparam logic [8:0] HP_ROW2 = 9'(RES_HZ / (2 * F_ROW2));
    localparam logic [8:0] HP_ROW3 = 9'(RES_HZ / (2 * F_ROW3));
    localparam logic [8:0] HP_ROW4 = 9'(RES_HZ / (2 * F_ROW4));
    localparam logic [8:0] HP_COL1 = 9'(RES_HZ / (2 * F_COL1));
    localparam logic [8:0] HP_COL2 = 9'(RES_HZ / (2 * F_COL2));
    localparam logic [8:0] HP_COL3 = 9'(RES_HZ / (2 * F_COL3));
    // ticks each alert tone lasts: half of the 20 Hz cycle
    localparam int ALT_TICKS = RES_HZ / (2 * F_ALT);
    // ring qualifier saturation default, resonator ticks
    localparam int RING_MAX = 2400;

    // ==========================================================
    // tone code layout and special codes
    localparam int CODE_W = 5;
    localparam logic [4:0] CODE_TWO_ROWS = 5'h0C; // rows 1+2, column 1
    localparam logic [4:0] CODE_TWO_COLS = 5'h0D; // row 1, columns 1+2
    localparam logic [4:0] CODE_DIAG     = 5'h0E; // rows 1+2, columns 1+2
    localparam logic [4:0] CODE_IDLE     = 5'h1F; // no key

    // ring qualifier states, gray along idle-qualify-alert
    typedef enum logic [1:0] {
        RAT_IDLE  = 2'b00,
        RAT_QUAL  = 2'b01,
        RAT_ALERT = 2'b11
    } rat_ring_e;

    // code to crosspoint pattern {rows[3:0], cols[2:0]}
    function automatic logic [6:0] rat_key_map(input logic [4:0] code);
        logic [6:0] pat;
        pat = 7'h00;
        if (code < 5'h0C) begin
            pat[6:3] = 4'(4'h1 << (code / 5'h03));
            pat[2:0] = 3'(3'h1 << (code % 5'h03));
        end else if (code == CODE_TWO_ROWS) begin
            pat = 7'h19;
        end else if (code == CODE_TWO_COLS) begin
            pat = 7'h0B;
        end else if (code == CODE_DIAG) begin
            pat = 7'h1B;
        end
        return pat;
    endfunction
endpackage
`default_nettype wire

// ### verif/rat_host_model.sv
// behavioural model of the controller that feeds tone codes and the alert select
// assumes one bench clock; requests come from the bench on i_send, one at a time
`timescale 1ns/1ps
`default_nettype none
module rat_host_model (
    input  wire logic       i_clk,               // bench clock
    input  wire logic       i_send,              // start one code transfer
    input  wire logic [4:0] i_code,              // code to present
    input  wire logic [3:0] i_hold,              // clocks per phase, 3 or more
    input  wire logic       i_alert_hi,          // wanted alert pair
    output logic            o_busy,              // transfer in progress
    output logic [4:0]      o_tone_code,         // code pins
    output logic            o_tone_code_strobe,  // strobe pin
    output logic            o_alert_freq_select  // select pin, driven not left open
);
    // ==========================================================
    // state
    logic [3:0] hold_r;                          // phase length of this transfer

    initial begin
        o_busy              = 1'b0;
        o_tone_code         = 5'h1F;
        o_tone_code_strobe  = 1'b0;
        o_alert_freq_select = 1'b0;
        hold_r              = 4'h3;
    end

    // ==========================================================
    // select pin follows the bench's wish one clock later
    always @(posedge i_clk) begin
        o_alert_freq_select <= i_alert_hi;
    end

    // ==========================================================
    // transfer: code first, strobe pulse, then settle
    // hold varies so the device sees both prompt and slow strobes
    always begin
        @(posedge i_clk);
        if (i_send) begin
            hold_r = i_hold;
            o_busy      <= 1'b1;
            o_tone_code <= i_code;
            repeat (hold_r) @(posedge i_clk);
            o_tone_code_strobe <= 1'b1;
            repeat (hold_r) @(posedge i_clk);
            o_tone_code_strobe <= 1'b0;
            repeat (hold_r) @(posedge i_clk);
            o_busy <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// ### verif/test_ringer_alerter_tone_control.sv
// self-checking bench for the ringer, alerter and tone-code block
// assumes rat_pkg, rat_core and rat_host_model are compiled first
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin fail_count++; $display("[ERR] %0t got %0d want %0d", $time, (g), (e)); end end
module test_ringer_alerter_tone_control;
    // ==========================================================
    // signals
    localparam int TK = rat_pkg::RES_DIV;        // clocks per resonator tick
    typedef struct { int row; int col; int win; int dial; } rat_exp_s;
    logic clk = 1'b0, reset_n = 1'b0, ring = 1'b0, hook = 1'b1, ll = 1'b0;
    logic send = 1'b0, alert_hi = 1'b0, busy, strobe, sel_pin;
    logic [4:0] code = 5'h00, tcode;
    logic [3:0] hold = 4'h3;
    logic al_a, al_b, ring_det, flag_out, flag_oe, row_t, col_t, dial, rx_att;
    int fail_count = 0, checks_done = 0, seed = 74, i, n;
    rat_exp_s sb [$];                            // tone expectations, oldest first
    int rq [$];                                  // alert expectations in clocks
    int t_code [7] = '{0, 5, 7, 9, 12, 13, 14};  // keys cover every row and column
    int t_row [7] = '{int'(rat_pkg::HP_ROW1) * TK, int'(rat_pkg::HP_ROW2) * TK,
                      int'(rat_pkg::HP_ROW3) * TK, int'(rat_pkg::HP_ROW4) * TK, 0,
                      int'(rat_pkg::HP_ROW1) * TK, 0};
    int t_col [7] = '{int'(rat_pkg::HP_COL1) * TK, int'(rat_pkg::HP_COL3) * TK,
                      int'(rat_pkg::HP_COL2) * TK, int'(rat_pkg::HP_COL1) * TK,
                      int'(rat_pkg::HP_COL1) * TK, 0, 0};

    initial begin
        forever #25 clk = ~clk;                  // 20 MHz
    end

    // ==========================================================
    // controller model and device
    rat_host_model host (.i_clk(clk), .i_send(send), .i_code(code), .i_hold(hold),
        .i_alert_hi(alert_hi), .o_busy(busy), .o_tone_code(tcode),
        .o_tone_code_strobe(strobe), .o_alert_freq_select(sel_pin));
    // tone swap just after the slowest first half period, so the first rise measured for either pair comes from its first tone
    rat_core #(.RING_MAX(8), .ALT_TICKS(205)) uut (.i_clk(clk), .i_reset_n(reset_n),
        .i_ring_level(ring), .i_hook_switch_sense(hook), .i_long_loop(ll),
        .i_alert_freq_select(sel_pin), .i_tone_code(tcode), .i_tone_code_strobe(strobe),
        .o_alert_out_a(al_a), .o_alert_out_b(al_b), .o_ring_detected(ring_det),
        .o_feature_mode_flag_out(flag_out), .o_feature_mode_flag_oe(flag_oe),
        .o_row_tone(row_t), .o_col_tone(col_t), .o_dial_active(dial), .o_rx_attenuate(rx_att));

    // ==========================================================
    // helpers
    // within two ticks counts as a match; zero means no edge at all
    function automatic logic near(input int m, input int e);
        if (e == 0) return (m == 0);
        return (m >= e - 2 * TK) && (m <= e + 2 * TK);
    endfunction

    // clocks from now to the first rise of each watched output
    task automatic measure(input int win, input bit alert, output int t1, output int t2);
        logic p1, p2, s1;
        t1 = 0;
        t2 = 0;
        p1 = alert ? al_a : row_t;
        p2 = col_t;
        for (int k = 1; k <= win; k++) begin
            @(negedge clk);
            s1 = alert ? al_a : row_t;
            if (t1 == 0 && s1 === 1'b1 && p1 !== 1'b1) t1 = k;
            if (t2 == 0 && col_t === 1'b1 && p2 !== 1'b1) t2 = k;
            p1 = s1;
            p2 = col_t;
        end
    endtask

    // one code transfer through the controller model
    task automatic send_code(input logic [4:0] c, input logic [3:0] h);
        @(posedge clk);
        code <= c;
        hold <= h;
        send <= 1'b1;
        @(posedge clk);
        send <= 1'b0;
        repeat (2) @(posedge clk);
        for (int k = 0; k < 40 && busy === 1'b1; k++) @(posedge clk);
        `CHK(busy, 1'b0);
    endtask

    // bounded wait for the watcher to use up its note
    task automatic wait_empty(input int lim);
        for (int k = 0; k < lim && sb.size() + rq.size() != 0; k++) @(posedge clk);
        `CHK(sb.size() + rq.size(), 0);
    endtask

    // ==========================================================
    // watchers: each strobe or ring decision is matched against the oldest note
    always @(posedge strobe) begin
        rat_exp_s e;
        int tr, tc;
        if (sb.size() != 0) begin
            e = sb[0];
            measure(e.win, 1'b0, tr, tc);
            `CHK(near(tr, e.row), 1'b1);
            `CHK(near(tc, e.col), 1'b1);
            if (e.dial >= 0) `CHK(dial, 1'(e.dial));
            if (e.dial >= 0) `CHK(rx_att, 1'(e.dial));
            void'(sb.pop_front());
        end
    end

    always @(posedge ring_det) begin
        int ta, tb;
        if (rq.size() != 0) begin
            @(negedge clk);
            `CHK({al_a, al_b}, 2'b01);
            measure(rq[0] + 4 * TK, 1'b1, ta, tb);
            `CHK(near(ta, rq[0]), 1'b1);
            void'(rq.pop_front());
        end
    end

    // ==========================================================
    // main sequence
    initial begin
        repeat (3) @(posedge clk);
        reset_n <= 1'b1;
        repeat (6) @(posedge clk);
        `CHK({flag_out, flag_oe}, 2'b01);
        for (i = 0; i < 7; i++) begin
            n = (t_row[i] > t_col[i]) ? t_row[i] : t_col[i];
            sb.push_back('{t_row[i], t_col[i], (n == 0) ? 260 * TK : n + 5 * TK, (i < 6) ? 1 : 0});
            send_code(5'(t_code[i]), 4'(3 + ($random(seed) & 3)));
            wait_empty(16000);
            hook <= 1'b0;
            repeat (7) @(posedge clk);
            `CHK({dial, rx_att, row_t, col_t}, 4'h0);
            hook <= 1'b1;
            repeat (6) @(posedge clk);
            $display("tone code %0d done", t_code[i]);
        end
        ll <= 1'b1;
        repeat (6) @(posedge clk);
        `CHK(flag_oe, 1'b0);
        sb.push_back('{0, 0, 600, 0});
        send_code(5'h00, 4'h3);
        wait_empty(800);
        ll <= 1'b0;
        hook <= 1'b0;
        repeat (6) @(posedge clk);
        sb.push_back('{0, 0, 600, 0});
        send_code(5'h04, 4'h4);
        wait_empty(800);
        $display("refused codes done");
        n = 1 + ($random(seed) & 3);
        ring <= 1'b1;
        repeat (n * TK) @(posedge clk);
        ring <= 1'b0;
        repeat (9 * TK) @(posedge clk);
        `CHK({ring_det, al_a, al_b}, 3'h0);
        alert_hi <= 1'($random(seed) & 1);
        repeat (5) @(posedge clk);
        rq.push_back(int'(alert_hi ? rat_pkg::HP_AL_HI0 : rat_pkg::HP_AL_LO0) * TK);
        ring <= 1'b1;
        repeat (6 * TK) @(posedge clk);
        `CHK(ring_det, 1'b0);
        wait_empty(9000);
        repeat (64 * TK) @(posedge clk); // keep ringing past the first tone swap with the low pair; with the high pair ring drops just before it
        ring <= 1'b0;
        repeat (10 * TK) @(posedge clk);
        `CHK({ring_det, al_a, al_b}, 3'h0);
        $display("ringing done, select %0d", alert_hi);
        summarize();
    end

    // ==========================================================
    // watchdog sized from the tone windows above
    initial begin
        repeat (100000) @(posedge clk);
        fail_count++;
        summarize();
    end

    task automatic summarize();
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
endmodule
`default_nettype wire
